// ---- design/gpab_regs.svh ----
// Purpose: Register indices, field positions and reset values of the port A/B I/O block.
// Assumes: Indices are word numbers; the APB byte address is four times the index.
// Notes:   Definitions only.
`ifndef GPAB_REGS_SVH
`define GPAB_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define GPAB_IDX_PORT_A_DATA      8'h05
`define GPAB_IDX_PORT_B_DATA      8'h06
`define GPAB_IDX_INTERRUPT_CTRL   8'h0b
`define GPAB_IDX_OPTION_CONTROL   8'h81
`define GPAB_IDX_PORT_A_DIRECTION 8'h85
`define GPAB_IDX_PORT_B_DIRECTION 8'h86

// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define GPAB_PA_MASK_FULL    8'h3f
`define GPAB_PA_MASK_REDUCED 8'h1f
`define GPAB_BIT_PA_TIMER    4
`define GPAB_BIT_PA_SS       5
`define GPAB_BIT_PULLUP_N    7
`define GPAB_BIT_CHANGE_FLAG 0
`define GPAB_BIT_PB_INT      0
`define GPAB_BIT_PB_PCLK     6
`define GPAB_BIT_PB_PDATA    7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GPAB_RST_LATCH  8'h00
`define GPAB_RST_OPTION 8'hff
`define GPAB_RST_DIR_B  8'hff
`define GPAB_RST_ZERO   8'h00

`endif

// ---- design/gpab_pkg.sv ----
// Purpose: Types shared by the port A/B I/O block.
// Assumes: Constants live in gpab_regs.svh.
// Notes:   Nothing here is imported; users write gpab_pkg::name.
package gpab_pkg;

    // ------------------------------------------------------------------------
    // Register selection
    // ------------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        GPAB_REG_NONE  = 3'h0,
        GPAB_REG_PA    = 3'h1,
        GPAB_REG_PB    = 3'h3,
        GPAB_REG_INTC  = 3'h2,
        GPAB_REG_OPT   = 3'h6,
        GPAB_REG_DIR_A = 3'h7,
        GPAB_REG_DIR_B = 3'h5
    } gpab_reg_e;

    // ------------------------------------------------------------------------
    // Pin drive carrier
    // ------------------------------------------------------------------------
    typedef struct packed
    {
        logic [7:0] out;
        logic [7:0] oe;
    } gpab_drive_s;

endpackage : gpab_pkg

// ---- design/gpab_ports.sv ----
// Purpose: Port A (6 bit) and port B (8 bit) general-purpose I/O with port B change detection.
// Assumes: APB slave on pclk; pins are synchronous to pclk; presetn is the power-on/brown-out reset.
// Notes:   Timer, serial port, external interrupt and programming logic sit outside; only their pin taps are here.
//
// Notes on behaviour
// (R01) Port A bit 4 output is open drain: pulls low for zero, released for one.
// (R02) Port A bit 4 pin level also goes to the timer clock input.
// (R03) Port A bit 5 pin level also goes to the serial port slave select.
// (R04) Port A data and direction bits 7 and 6 read zero and ignore writes.
// (R05) Reduced variant: port A bit 5 data and direction absent, read zero.
// (R06) Power-on reset sets port A direction to all ones, all inputs.
// (R07) Other resets keep data latches and set direction registers to all ones.
// (R08) Port B is 8 bits; direction one floats the pin, zero drives the latch.
// (R09) Option bit 7, active low, enables weak pull-ups on all port B pins.
// (R10) A port B pull-up is off whenever that pin is an output.
// (R11) Power-on reset sets option to all ones, pull-ups disabled.
// (R12) Only port B pins 7 to 4 set as inputs take part in change detection.
// (R13) Reading port B latches pins 7 to 4; live inputs are compared to it.
// (R14) Mismatches are ORed and set the change flag at interrupt control bit 0.
// (R15) A port B change mismatch can wake the core from sleep.
// (R16) Any port B read or write ends the mismatch; persisting mismatch keeps setting.
// (R17) Older variant may miss a change that coincides with a port B read.
// (R18) Port B bit 0 pin level also goes to the external interrupt logic.
// (R19) In serial programming mode port B bit 6 is clock, bit 7 data.
// (R20) Port A read returns pin levels; write updates only the output latch.
// (R21) Port A direction one floats the pin, zero drives the latch bit.
// (R22) Port B read returns pin levels; write updates only the output latch.
`timescale 1ns/1ns
`include "gpab_regs.svh"

module gpab_ports #(
    parameter int          ADDR_W      = 12,
    parameter bit          REDUCED     = 1'b0,
    parameter bit          OLD_VARIANT = 1'b0
) (
    // Clock, reset, enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              soft_rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Port A pins
    input  wire logic [5:0]        pa_in,
    output logic      [5:0]        pa_out,
    output logic      [5:0]        pa_oe,
    // Port B pins
    input  wire logic [7:0]        pb_in,
    output logic      [7:0]        pb_out,
    output logic      [7:0]        pb_oe,
    output logic      [7:0]        pb_pullup_en,
    // Peripheral taps
    output logic                   timer_ext_clock_in,
    output logic                   ssp_slave_select,
    output logic                   ext_int_in,
    output logic                   port_change_flag,
    output logic                   wake_req,
    // Serial programming
    input  wire logic              prog_mode,
    input  wire logic              prog_data_out,
    input  wire logic              prog_data_oe,
    output logic                   prog_clk,
    output logic                   prog_data_in
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (ADDR_W < 10 || ADDR_W > 32)
    begin : g_bad_addr
        $error("gpab_ports: ADDR_W must be 10 to 32");
    end

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    localparam logic [7:0] PA_MASK = REDUCED ? `GPAB_PA_MASK_REDUCED : `GPAB_PA_MASK_FULL;

    // Misaligned or out-of-range addresses decode to no register and raise pslverr.
    function automatic gpab_pkg::gpab_reg_e decode(input logic [ADDR_W-1:0] a);
        gpab_pkg::gpab_reg_e r;
        r = gpab_pkg::GPAB_REG_NONE;
        if (a[1:0] == 2'h0 && (a >> 10) == '0)
        begin
            case (a[9:2])
                `GPAB_IDX_PORT_A_DATA:      r = gpab_pkg::GPAB_REG_PA;
                `GPAB_IDX_PORT_B_DATA:      r = gpab_pkg::GPAB_REG_PB;
                `GPAB_IDX_INTERRUPT_CTRL:   r = gpab_pkg::GPAB_REG_INTC;
                `GPAB_IDX_OPTION_CONTROL:   r = gpab_pkg::GPAB_REG_OPT;
                `GPAB_IDX_PORT_A_DIRECTION: r = gpab_pkg::GPAB_REG_DIR_A;
                `GPAB_IDX_PORT_B_DIRECTION: r = gpab_pkg::GPAB_REG_DIR_B;
                default:                    r = gpab_pkg::GPAB_REG_NONE;
            endcase
        end
        return r;
    endfunction : decode

    gpab_pkg::gpab_reg_e sel;
    logic                setup;
    logic                xfer;
    logic                wr;
    logic                rd;

    assign sel     = decode(paddr);
    assign setup   = ce && psel && !penable;
    // The slave inserts no wait states while enabled; a low enable stalls the bus instead of losing a beat.
    assign pready  = ce;
    assign xfer    = ce && psel && penable;
    assign wr      = xfer && pwrite;
    assign rd      = xfer && !pwrite;
    assign pslverr = psel && penable && (sel == gpab_pkg::GPAB_REG_NONE);

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0] lat_a_q;
    logic [7:0] lat_b_q;
    logic [7:0] dir_a_q;
    logic [7:0] dir_b_q;
    logic [7:0] opt_q;
    logic [3:0] snap_q;
    logic       flag_q;
    logic [7:0] prdata_q;

    // Data latches survive the soft reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lat_a_q <= `GPAB_RST_LATCH;
            lat_b_q <= `GPAB_RST_LATCH;
        end
        else if (ce && !soft_rst)                                      // R07
        begin
            if (wr && sel == gpab_pkg::GPAB_REG_PA)
                lat_a_q <= pwdata[7:0] & PA_MASK;                      // R04 R05 R20
            if (wr && sel == gpab_pkg::GPAB_REG_PB)
                lat_b_q <= pwdata[7:0];                                // R22
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_a_q <= PA_MASK;                                        // R06
            dir_b_q <= `GPAB_RST_DIR_B;
            opt_q   <= `GPAB_RST_OPTION;                               // R11
        end
        else if (ce)
        begin
            if (soft_rst)
            begin
                dir_a_q <= PA_MASK;                                    // R07
                dir_b_q <= `GPAB_RST_DIR_B;
                opt_q   <= `GPAB_RST_OPTION;
            end
            else if (wr)
            begin
                if (sel == gpab_pkg::GPAB_REG_DIR_A)
                    dir_a_q <= pwdata[7:0] & PA_MASK;                  // R04 R05
                if (sel == gpab_pkg::GPAB_REG_DIR_B)
                    dir_b_q <= pwdata[7:0];
                if (sel == gpab_pkg::GPAB_REG_OPT)
                    opt_q <= pwdata[7:0];
            end
        end
    end

    // Read data is captured in the setup cycle so that prdata comes from a flip-flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= `GPAB_RST_ZERO;
        else if (setup)
        begin
            case (sel)
                gpab_pkg::GPAB_REG_PA:    prdata_q <= {2'h0, pa_in} & PA_MASK;   // R04 R05 R20
                gpab_pkg::GPAB_REG_PB:    prdata_q <= pb_in;                     // R22
                gpab_pkg::GPAB_REG_INTC:  prdata_q <= {7'h00, flag_q};
                gpab_pkg::GPAB_REG_OPT:   prdata_q <= opt_q;
                gpab_pkg::GPAB_REG_DIR_A: prdata_q <= dir_a_q;
                gpab_pkg::GPAB_REG_DIR_B: prdata_q <= dir_b_q;
                default:                  prdata_q <= `GPAB_RST_ZERO;
            endcase
        end
    end

    assign prdata = {24'h000000, prdata_q};

    // ------------------------------------------------------------------------
    // Change detection
    // ------------------------------------------------------------------------
    logic [3:0] mismatch;
    logic       pb_read;
    logic       pb_touch;
    logic       set_flag;

    assign pb_read  = rd && sel == gpab_pkg::GPAB_REG_PB;
    assign pb_touch = xfer && sel == gpab_pkg::GPAB_REG_PB;
    assign mismatch = (pb_in[7:4] ^ snap_q) & dir_b_q[7:4];           // R12 R13
    // The older variant drops a change that lands on a port B read or write beat itself.
    assign set_flag = (|mismatch) && !(OLD_VARIANT && pb_touch);      // R14 R17

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            snap_q <= 4'h0;
        else if (ce && pb_touch)
            snap_q <= pb_read ? prdata_q[7:4] : pb_in[7:4];            // R13 R16
    end

    // Hardware set wins over a software clear in the same beat.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_q <= 1'b0;
        else if (ce)
        begin
            if (soft_rst)
                flag_q <= 1'b0;
            else if (set_flag)
                flag_q <= 1'b1;                                        // R14 R16
            else if (wr && sel == gpab_pkg::GPAB_REG_INTC)
                flag_q <= pwdata[`GPAB_BIT_CHANGE_FLAG];
        end
    end

    assign port_change_flag = flag_q;
    assign wake_req         = |mismatch;                               // R15

    // ------------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------------
    gpab_pkg::gpab_drive_s drv_a;
    gpab_pkg::gpab_drive_s drv_b;

    // Port A bit 4 never drives high; a latched one leaves the pin to the board.
    always_comb
    begin
        drv_a.out = lat_a_q & PA_MASK;
        drv_a.oe  = ~dir_a_q & PA_MASK;                                // R21
        drv_a.out[`GPAB_BIT_PA_TIMER] = 1'b0;                          // R01
        drv_a.oe[`GPAB_BIT_PA_TIMER]  = !dir_a_q[`GPAB_BIT_PA_TIMER] && !lat_a_q[`GPAB_BIT_PA_TIMER];  // R01
        drv_b.out = lat_b_q;
        drv_b.oe  = ~dir_b_q;                                          // R08
        if (prog_mode)
        begin
            drv_b.oe[`GPAB_BIT_PB_PCLK]   = 1'b0;                      // R19
            drv_b.out[`GPAB_BIT_PB_PDATA] = prog_data_out;
            drv_b.oe[`GPAB_BIT_PB_PDATA]  = prog_data_oe;
        end
    end

    assign pa_out       = drv_a.out[5:0];
    assign pa_oe        = drv_a.oe[5:0];
    assign pb_out       = drv_b.out;
    assign pb_oe        = drv_b.oe;
    // Outside programming mode an output pin never fights its own pull-up.
    assign pb_pullup_en = {8{!opt_q[`GPAB_BIT_PULLUP_N]}} & dir_b_q;   // R09 R10

    assign timer_ext_clock_in = pa_in[`GPAB_BIT_PA_TIMER];             // R02
    assign ssp_slave_select   = REDUCED ? 1'b0 : pa_in[`GPAB_BIT_PA_SS];  // R03
    assign ext_int_in         = pb_in[`GPAB_BIT_PB_INT];               // R18
    assign prog_clk           = pb_in[`GPAB_BIT_PB_PCLK];              // R19
    assign prog_data_in       = pb_in[`GPAB_BIT_PB_PDATA];

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_pb_read;
        rd && sel == gpab_pkg::GPAB_REG_PB && !soft_rst && $stable(pb_in);
    endsequence

    sequence s_pins_quiet;
        ce && $stable(pb_in) && $stable(dir_b_q);
    endsequence

    sequence s_pb_write;
        wr && sel == gpab_pkg::GPAB_REG_PB && !soft_rst;
    endsequence

    a_od_never_high: assert property (@(posedge pclk) disable iff (!presetn)           // R01
        pa_oe[4] |-> !pa_out[4] && !lat_a_q[4])
        else $error("open-drain pin driven while latch is one");

    a_od_release: assert property (@(posedge pclk) disable iff (!presetn)              // R01
        wr && sel == gpab_pkg::GPAB_REG_PA && pwdata[4] && !soft_rst |=> !pa_oe[4])
        else $error("open-drain pin not released after writing one");

    a_timer_tap: assert property (@(posedge pclk) disable iff (!presetn)               // R02
        timer_ext_clock_in == pa_in[4] && ext_int_in == pb_in[0])                      // R18
        else $error("peripheral tap does not follow pin");

    a_ss_tap: assert property (@(posedge pclk) disable iff (!presetn)                  // R03
        !REDUCED |-> ssp_slave_select == pa_in[5])
        else $error("slave select does not follow pin");

    a_pa_read_mask: assert property (@(posedge pclk) disable iff (!presetn)            // R04
        setup && !pwrite && sel == gpab_pkg::GPAB_REG_PA |=> prdata[7:6] == 2'h0
            && (REDUCED ? prdata[5] == 1'b0 : prdata[5] == $past(pa_in[5])))           // R05
        else $error("port A read shows unimplemented bits");

    a_soft_reset: assert property (@(posedge pclk) disable iff (!presetn)              // R07
        ce && soft_rst |=> dir_a_q == PA_MASK && dir_b_q == `GPAB_RST_DIR_B && $stable(lat_b_q))
        else $error("soft reset mishandled direction or latch");

    a_pullup_rule: assert property (@(posedge pclk) disable iff (!presetn)             // R10
        (pb_pullup_en & ~dir_b_q) == 8'h00 && (!opt_q[7] || pb_pullup_en == 8'h00))   // R09
        else $error("pull-up on while output or disabled");

    a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)               // R14
        ce && (|mismatch) && !pb_touch && !soft_rst |=> flag_q)
        else $error("mismatch did not set change flag");

    a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)             // R16
        s_pb_read ##1 s_pins_quiet |-> mismatch == 4'h0)
        else $error("port B read did not end mismatch");

    a_wake_on_change: assert property (@(posedge pclk) disable iff (!presetn)          // R15
        ce && wake_req && !soft_rst && !(OLD_VARIANT && pb_touch) |=> port_change_flag)  // R14
        else $error("wake request without change flag");

    a_change_excl: assert property (@(posedge pclk) disable iff (!presetn)             // R12
        dir_b_q[7:4] == 4'h0 |-> !wake_req)
        else $error("output pin took part in change detection");

    // A low enable must hold every register, the soft reset included.
    a_ce_freeze: assert property (@(posedge pclk) disable iff (!presetn)               // R07
        !ce |=> $stable(lat_a_q) && $stable(lat_b_q) && $stable(dir_a_q) && $stable(dir_b_q)
            && $stable(opt_q) && $stable(flag_q) && $stable(snap_q))
        else $error("state moved while clock enable low");

    a_pa_dir_mask: assert property (@(posedge pclk) disable iff (!presetn)             // R04
        (dir_a_q & ~PA_MASK) == 8'h00 && (lat_a_q & ~PA_MASK) == 8'h00)                // R05
        else $error("unimplemented port A bit stored");

    a_pa_read_pins: assert property (@(posedge pclk) disable iff (!presetn)            // R20
        setup && !pwrite && sel == gpab_pkg::GPAB_REG_PA |=> prdata[4:0] == $past(pa_in[4:0]))
        else $error("port A read does not show pins");

    a_pb_read_pins: assert property (@(posedge pclk) disable iff (!presetn)            // R22
        setup && !pwrite && sel == gpab_pkg::GPAB_REG_PB |=> prdata[7:0] == $past(pb_in))
        else $error("port B read does not show pins");

    a_pb_drive: assert property (@(posedge pclk) disable iff (!presetn)                // R08
        !prog_mode |-> pb_oe == ~dir_b_q && pb_out == lat_b_q)
        else $error("port B drive does not follow latch and direction");

    a_prog_pins: assert property (@(posedge pclk) disable iff (!presetn)               // R19
        prog_mode |-> !pb_oe[6] && pb_oe[7] == prog_data_oe && pb_out[7] == prog_data_out)
        else $error("programming pins not handed over");

    // A port B write re-arms the comparison from the pins as they stood at the write.
    a_write_clears: assert property (@(posedge pclk) disable iff (!presetn)            // R16
        s_pb_write |=> snap_q == $past(pb_in[7:4]))
        else $error("port B write did not refresh snapshot");

    a_intc_read: assert property (@(posedge pclk) disable iff (!presetn)               // R14
        setup && !pwrite && sel == gpab_pkg::GPAB_REG_INTC |=> prdata[7:0] == {7'h00, $past(flag_q)})
        else $error("change flag not readable");

    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)              // R16
        ce && !soft_rst && wr && sel == gpab_pkg::GPAB_REG_INTC && !pwdata[0] && !set_flag |=> !flag_q)
        else $error("change flag not cleared by software");

endmodule : gpab_ports

// ---- tb/gpab_pin_model.sv ----
// Purpose: Board side of the port A/B pins: external drivers, weak pull-ups and open-drain release.
// Assumes: Design drive wins over the board; the bench drives input pins through ext_a and ext_b.
// Notes:   A port B pin with nothing driving it and no pull-up toggles, as a real floating pin may.
`timescale 1ns/1ns

module gpab_pin_model (
    // Clock
    input  wire logic       pclk,
    // Design pin drive
    input  wire logic [5:0] pa_out,
    input  wire logic [5:0] pa_oe,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe,
    input  wire logic [7:0] pb_pullup_en,
    // Board drive
    input  wire logic [5:0] ext_a,
    input  wire logic [7:0] ext_b,
    input  wire logic       ext_b_en,
    // Resolved levels
    output logic      [5:0] pa_in,
    output logic      [7:0] pb_in
);
    logic [7:0] last_b = 8'h00;

    // A released open-drain pin takes the board level, which models the external pull-up.
    always_comb
    begin
        for (int i = 0; i < 6; i++)
            pa_in[i] = pa_oe[i] ? pa_out[i] : ext_a[i];
        for (int i = 0; i < 8; i++)
            pb_in[i] = pb_oe[i] ? pb_out[i] : ext_b_en ? ext_b[i] : pb_pullup_en[i] ? 1'b1 : ~last_b[i];
    end

    always @(posedge pclk)
        last_b <= pb_in;
endmodule : gpab_pin_model

// ---- tb/gpab_ports_tb_top.sv ----
// Purpose: Self-checking bench of the port A/B I/O block against a register and pin model.
// Assumes: APB answers when pready is high; the board model resolves every pin.
// Notes:   Expected pin levels are worked out here from latches, directions and board drive.
`timescale 1ns/1ns
`include "gpab_regs.svh"

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("Error t=%0t got %0h exp %0h", $time, (a), (e)); end end

module gpab_ports_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, soft_rst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdq;
    logic pready, pslverr, errq;
    logic [5:0] pa_in, pa_out, pa_oe, ext_a = 6'h00;
    logic [7:0] pb_in, pb_out, pb_oe, pb_pullup_en, ext_b = 8'h00;
    logic ext_b_en = 1'b1, prog_mode = 1'b0, prog_data_out = 1'b0, prog_data_oe = 1'b0;
    logic t_clk, t_ss, t_int, chg, wake, p_clk, p_dat;
    logic [7:0] la = 8'h00, da = 8'h3f, lb = 8'h00, db = 8'hff, eb, ea;
    int n_errors = 0, num_checks = 0, rv;

    always #5 pclk = ~pclk;

    gpab_ports u_gpab_ports (.pclk(pclk), .presetn(presetn), .ce(ce), .soft_rst(soft_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out),
        .pb_oe(pb_oe), .pb_pullup_en(pb_pullup_en), .timer_ext_clock_in(t_clk), .ssp_slave_select(t_ss),
        .ext_int_in(t_int), .port_change_flag(chg), .wake_req(wake), .prog_mode(prog_mode),
        .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe), .prog_clk(p_clk), .prog_data_in(p_dat));

    gpab_pin_model u_gpab_pin_model (.pclk(pclk), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
        .pb_oe(pb_oe), .pb_pullup_en(pb_pullup_en), .ext_a(ext_a), .ext_b(ext_b), .ext_b_en(ext_b_en),
        .pa_in(pa_in), .pb_in(pb_in));

    // ------------------------------------------------------------------------
    // Model and bus tasks
    // ------------------------------------------------------------------------
    function automatic logic [7:0] exp_pa();
        logic [7:0] e;
        e = (~da & la) | (da & {2'b00, ext_a});
        if (!da[4] && la[4])
            e[4] = ext_a[4];
        return e & 8'h3f;
    endfunction : exp_pa

    function automatic logic [7:0] exp_pb();
        return (~db & lb) | (db & (ext_b_en ? ext_b : 8'hff));
    endfunction : exp_pb

    function automatic logic [5:0] oe_a();
        logic [5:0] o;
        o = ~da[5:0];
        o[4] = o[4] & ~la[4];
        return o;
    endfunction : oe_a

    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // Called just after a rising edge; the request stands until pready is seen high.
    // One idle edge follows, so callers see outputs settled after the access edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 50);
        if (i >= 50)
        begin
            n_errors++;
            tally_and_finish();
        end
        rdq = prdata;
        errq = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, d);
        `CHK(errq, 1'b0)
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
        `CHK(rdq, {24'h0, e})
        `CHK(errq, 1'b0)
    endtask : rd

    initial
    begin
        #500000;
        n_errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    initial
    begin
        rv = $urandom(32'ha2214f55);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`GPAB_IDX_OPTION_CONTROL, 8'hff);
        rd(`GPAB_IDX_PORT_A_DIRECTION, 8'h3f);
        rd(`GPAB_IDX_PORT_B_DIRECTION, 8'hff);
        `CHK({pb_pullup_en, pa_oe, pb_oe}, 22'h0)
        repeat (24)
        begin
            la = 8'($urandom);
            da = 8'($urandom);
            lb = 8'($urandom);
            db = 8'($urandom);
            ext_a <= 6'($urandom);
            ext_b <= 8'($urandom);
            wr(`GPAB_IDX_PORT_A_DATA, la);
            wr(`GPAB_IDX_PORT_A_DIRECTION, da);
            wr(`GPAB_IDX_PORT_B_DATA, lb);
            wr(`GPAB_IDX_PORT_B_DIRECTION, db);
            la &= 8'h3f;
            da &= 8'h3f;
            `CHK(pa_oe, oe_a())
            `CHK(pa_out & pa_oe, la[5:0] & oe_a())
            `CHK({pb_oe, pb_out & pb_oe}, {~db, lb & ~db})
            rd(`GPAB_IDX_PORT_A_DIRECTION, da);
            rd(`GPAB_IDX_PORT_A_DATA, exp_pa());
            eb = exp_pb();
            rd(`GPAB_IDX_PORT_B_DATA, eb);
            ea = exp_pa();
            `CHK({t_clk, t_ss, t_int, p_clk, p_dat}, {ea[4], ea[5], eb[0], eb[6], eb[7]})
        end
        wr(`GPAB_IDX_OPTION_CONTROL, 8'h7f);
        db = 8'($urandom);
        wr(`GPAB_IDX_PORT_B_DIRECTION, db);
        `CHK(pb_pullup_en, db)
        ext_b_en <= 1'b0;
        @(posedge pclk);
        rd(`GPAB_IDX_PORT_B_DATA, exp_pb());
        ext_b_en <= 1'b1;
        ext_b <= 8'h00;
        db = 8'h80;
        wr(`GPAB_IDX_PORT_B_DIRECTION, db);
        rd(`GPAB_IDX_PORT_B_DATA, exp_pb());
        wr(`GPAB_IDX_INTERRUPT_CTRL, 8'h00);
        rd(`GPAB_IDX_INTERRUPT_CTRL, 8'h00);
        ext_b <= 8'h40;
        lb ^= 8'h40;
        wr(`GPAB_IDX_PORT_B_DATA, lb);
        repeat (3) @(posedge pclk);
        `CHK({chg, wake}, 2'b00)
        ext_b <= 8'hc0;
        repeat (3) @(posedge pclk);
        `CHK({chg, wake}, 2'b11)
        wr(`GPAB_IDX_INTERRUPT_CTRL, 8'h00);
        rd(`GPAB_IDX_INTERRUPT_CTRL, 8'h01);
        rd(`GPAB_IDX_PORT_B_DATA, exp_pb());
        `CHK(wake, 1'b0)
        wr(`GPAB_IDX_INTERRUPT_CTRL, 8'h00);
        `CHK(chg, 1'b0)
        ext_b <= 8'h40;
        repeat (3) @(posedge pclk);
        `CHK(wake, 1'b1)
        wr(`GPAB_IDX_PORT_B_DATA, lb);
        `CHK(wake, 1'b0)
        apb(1'b0, 12'h100, 8'h00);
        `CHK({errq, rdq}, 33'h1_0000_0000)
        soft_rst <= 1'b1;
        @(posedge pclk);
        soft_rst <= 1'b0;
        @(posedge pclk);
        rd(`GPAB_IDX_PORT_A_DIRECTION, 8'h3f);
        rd(`GPAB_IDX_PORT_B_DIRECTION, 8'hff);
        da = 8'h00;
        wr(`GPAB_IDX_PORT_A_DIRECTION, da);
        `CHK(pa_out & pa_oe, la[5:0] & oe_a())
        ce <= 1'b0;
        soft_rst <= 1'b1;
        @(posedge pclk);
        ce <= 1'b1;
        soft_rst <= 1'b0;
        rd(`GPAB_IDX_PORT_A_DIRECTION, da);
        prog_mode <= 1'b1;
        prog_data_oe <= 1'b1;
        prog_data_out <= 1'b1;
        db = 8'h00;
        wr(`GPAB_IDX_PORT_B_DIRECTION, db);
        `CHK({pb_oe[7:6], pb_out[7]}, 3'b101)
        prog_mode <= 1'b0;
        @(posedge pclk);
        tally_and_finish();
    end
endmodule : gpab_ports_tb_top
